/* File: rtl/vanc_pacer_pkg.sv */
// Shared constants and types for the serial stream pacer
package vanc_pacer_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int NUM_CH = 4;
  localparam int PTR_W = 5;
  localparam logic [5:0] FIFO_FULL = 6'h20;
  // Pause early: characters already in flight must still fit
  localparam logic [5:0] XOFF_LEVEL = 6'h18;
  localparam logic [5:0] XON_LEVEL = 6'h08;
  localparam logic [7:0] PAUSE_CHAR = 8'h13;
  localparam logic [7:0] RESUME_CHAR = 8'h11;
  localparam logic [15:0] RAW_STREAM_PORT = 16'h1E6C;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SERIAL = 8'h04;
  localparam logic [7:0] ADDR_NET = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_QUOTA0 = 8'h10;
  localparam logic [7:0] ADDR_LAST = 8'h1C;
  // Field positions
  localparam int CTRL_SER_EN = 0;
  localparam int CTRL_SER_CH = 1;
  localparam int CTRL_SER_DIR = 3;
  localparam int SER_DIFF = 0;
  localparam int SER_BAUD = 1;
  localparam int SER_BITS8 = 4;
  localparam int SER_PAR = 5;
  localparam int SER_STOP2 = 7;
  localparam int SER_FLOW = 8;
  localparam int NET_CLIENT = 0;
  localparam int NET_REAR = 4;
  localparam int NET_PORT = 16;
  localparam int ST_PAUSED = 0;
  localparam int ST_OVF = 1;
  localparam int ST_LEVEL = 8;
  // Reset values, parity and response codes, baud rates
  localparam logic [2:0] BAUD_RST = 3'h4;
  localparam logic [7:0] QUOTA_RST = 8'h64;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int BAUD_0 = 9600;
  localparam int BAUD_1 = 19200;
  localparam int BAUD_2 = 38400;
  localparam int BAUD_3 = 57600;
  localparam int BAUD_4 = 115200;
  typedef enum logic [1:0] {FLOW_RUN = 2'b01, FLOW_PAUSED = 2'b10} flow_state_type;
  // Clock cycles per serial bit for a baud code
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    case (sel)
      3'h0: baud_div = 16'(CLK_HZ / BAUD_0);
      3'h1: baud_div = 16'(CLK_HZ / BAUD_1);
      3'h2: baud_div = 16'(CLK_HZ / BAUD_2);
      3'h3: baud_div = 16'(CLK_HZ / BAUD_3);
      default: baud_div = 16'(CLK_HZ / BAUD_4);
    endcase
  endfunction
endpackage

/* File: rtl/serial_uart.sv */
// Asynchronous serial transmitter and receiver with run-time framing
`timescale 1ns/100ps
module serial_uart
  import vanc_pacer_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] divisor,
  input wire logic bits8,
  input wire logic [1:0] parity,
  input wire logic stop2,
  input wire logic rx_pin,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_busy,
  output logic tx_pin
);
  logic rx_meta, rx_sync, rx_busy;
  logic [15:0] rx_cnt, tx_cnt;
  logic [3:0] rx_idx, tx_idx, rx_len, tx_len;
  logic [8:0] rx_shift;
  logic [11:0] tx_frame;

  // Parity over the active data bits
  function automatic logic par_bit(input logic [7:0] d, input logic b8, input logic [1:0] m);
    par_bit = ^(b8 ? d : {1'b0, d[6:0]}) ^ (m == PAR_ODD);
  endfunction

  assign rx_len = 4'(bits8 ? 8 : 7) + 4'(parity != PAR_NONE);
  assign tx_len = rx_len + 4'(stop2 ? 3 : 2);

  // Two-stage synchroniser on the line
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
    end
  end

  // Receiver samples mid-bit; only the first stop bit is checked
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_busy <= 1'b0;
      rx_cnt <= 16'h0000;
      rx_idx <= 4'h0;
      rx_shift <= 9'h000;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy) begin
        if (!rx_sync) begin
          rx_busy <= 1'b1;
          rx_cnt <= divisor >> 1;
          rx_idx <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= divisor - 16'h0001;
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0) begin
          rx_busy <= ~rx_sync; // False start is dropped
        end else if (rx_idx <= rx_len) begin
          rx_shift[rx_idx - 4'h1] <= rx_sync;
        end else begin
          rx_busy <= 1'b0;
          // Framing or parity faults discard the character [R04]
          if (rx_sync && (parity == PAR_NONE ||
              par_bit(rx_shift[7:0], bits8, parity) == rx_shift[bits8 ? 8 : 7])) begin
            rx_valid <= 1'b1;
            rx_data <= bits8 ? rx_shift[7:0] : {1'b0, rx_shift[6:0]};
          end
        end
      end
    end
  end

  // Transmitter shifts a prebuilt frame, start bit first [R04]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_busy <= 1'b0;
      tx_cnt <= 16'h0000;
      tx_idx <= 4'h0;
      tx_frame <= 12'hFFF;
      tx_pin <= 1'b1;
    end else if (!tx_busy) begin
      tx_pin <= 1'b1;
      if (tx_start) begin
        tx_busy <= 1'b1;
        tx_cnt <= divisor - 16'h0001;
        tx_idx <= 4'h0;
        tx_pin <= 1'b0;
        tx_frame <= 12'hFFF;
        tx_frame[7:0] <= {tx_data[6:0], 1'b0};
        tx_frame[8] <= bits8 ? tx_data[7] : par_bit(tx_data, bits8, parity) | (parity == PAR_NONE);
        tx_frame[9] <= (bits8 && parity != PAR_NONE) ? par_bit(tx_data, bits8, parity) : 1'b1;
      end
    end else if (tx_cnt != 16'h0000) begin
      tx_cnt <= tx_cnt - 16'h0001;
    end else begin
      tx_cnt <= divisor - 16'h0001;
      tx_idx <= tx_idx + 4'h1;
      tx_frame <= {1'b1, tx_frame[11:1]};
      tx_pin <= tx_frame[1];
      if (tx_idx + 4'h1 == tx_len) begin
        tx_busy <= 1'b0;
        tx_pin <= 1'b1;
      end
    end
  end
endmodule

/* File: rtl/vanc_serial_stream_pacer.sv */
// Stream pacer: per-stream ingress buffers, quota drain, serial flow control
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
// Functional notes
// R01: Four insert and four extract streams, each with own source and settings.
// R02: All streams may use network; at most one uses the serial port.
// R03: Serial insert rate limited to min of baud and rate x 10 x quota.
// R04: Each serial byte carries one start and one stop bit; with stop2 set the code sends two stop bits.
// R05: Boundary is field tick when interlaced, frame tick when progressive.
// R06: Above reserved rate, pause and resume the sender in band.
// R07: Sender must obey pause; ignored pauses overflow and lose data.
// R08: Senders without flow control should pick a large enough quota.
// R09: Decode baud must be at least the extracted data rate.
// R10: Network insert stream accepts exactly quota bytes per boundary; code accepts while its buffer has room and drains at most quota per boundary.
// R11: Each network channel is client or listening server, server at reset.
// R12: Network raw channel uses socket port 7788.
// R13: Each network channel routes to shared frame jack or card rear jack.
// R14: Serial standard selectable, differential after reset.
// R15: Baud rate selectable, 115200 after reset.
// R16: Character length selectable, eight bits after reset.
// R17: Parity none, odd or even, none after reset.
// R18: Stop bits selectable, one after reset.
// R19: Flow control in-band or none, none after reset.
// R20: Pause is 0x13, resume is 0x11, pause sent before overflow.
// R21: Each boundary drains at most quota bytes per stream, rest kept.
module vanc_serial_stream_pacer
  import vanc_pacer_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic field_tick,
  input wire logic frame_tick,
  input wire logic progressive,
  input wire logic [3:0] net_in_valid,
  input wire logic [31:0] net_in_data,
  output logic [3:0] net_in_ready,
  output logic ins_valid,
  output logic [1:0] ins_chan,
  output logic [7:0] ins_data,
  input wire logic ins_ready,
  input wire logic ext_valid,
  input wire logic [1:0] ext_chan,
  input wire logic [7:0] ext_data,
  output logic ext_ready,
  output logic net_out_valid,
  output logic [1:0] net_out_chan,
  output logic [7:0] net_out_data,
  input wire logic net_out_ready,
  output logic [3:0] net_role_client,
  output logic [3:0] net_use_rear_jack,
  output logic [15:0] raw_stream_port,
  output logic ser_diff_mode,
  input wire logic ser_rx,
  output logic ser_tx
);
  ////////////////////////////////////////////////////////////////////////////
  logic ser_en, ser_dir, bits8, stop2, flow_on;
  logic [1:0] ser_ch, parity;
  logic [2:0] baud_sel;
  logic [3:0] ovf;
  logic [7:0] quota [NUM_CH];
  logic aw_got, w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, rd_fire;
  logic [31:0] rd_word;

  // Word-aligned decode inside the map; everything else is an error
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= ADDR_LAST) && (a[1:0] == 2'h0);
  endfunction

  // Address and data in either order; response follows both
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Write channel capture and response
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; byte lanes gate their own fields
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ser_en <= 1'b0;
      ser_ch <= 2'h0;
      ser_dir <= 1'b0;
      ser_diff_mode <= 1'b1; // [R14]
      baud_sel <= BAUD_RST; // [R15]
      bits8 <= 1'b1; // [R16]
      parity <= PAR_NONE; // [R17]
      stop2 <= 1'b0; // [R18]
      net_role_client <= 4'h0; // [R11]
      net_use_rear_jack <= 4'h0;
      for (int i = 0; i < NUM_CH; i++) begin
        quota[i] <= QUOTA_RST;
      end
    end else if (wr_fire && w_strb[0]) begin
      case (aw_addr)
        ADDR_CTRL: begin
          ser_en <= w_data[CTRL_SER_EN]; // [R02]
          ser_ch <= w_data[CTRL_SER_CH +: 2];
          ser_dir <= w_data[CTRL_SER_DIR];
        end
        ADDR_SERIAL: begin
          ser_diff_mode <= w_data[SER_DIFF]; // [R14]
          baud_sel <= w_data[SER_BAUD +: 3]; // [R15]
          bits8 <= w_data[SER_BITS8]; // [R16]
          parity <= w_data[SER_PAR +: 2]; // [R17]
          stop2 <= w_data[SER_STOP2]; // [R18]
        end
        ADDR_NET: begin
          net_role_client <= w_data[NET_CLIENT +: 4]; // [R11]
          net_use_rear_jack <= w_data[NET_REAR +: 4]; // [R13]
        end
        default: begin
          if (aw_addr >= ADDR_QUOTA0 && addr_ok(aw_addr)) begin
            quota[aw_addr[3:2]] <= w_data[7:0];
          end
        end
      endcase
    end
  end

  // Flow enable lives in byte lane 1
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flow_on <= 1'b0; // [R19]
    end else if (wr_fire && w_strb[1] && aw_addr == ADDR_SERIAL) begin
      flow_on <= w_data[SER_FLOW]; // [R19]
    end
  end

  assign raw_stream_port = RAW_STREAM_PORT; // [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Ingress buffers, one per insert stream [R01]
  logic [7:0] mem [NUM_CH][2**PTR_W];
  logic [PTR_W-1:0] wp [NUM_CH];
  logic [PTR_W-1:0] rp [NUM_CH];
  logic [5:0] cnt [NUM_CH];
  logic [7:0] credit [NUM_CH];
  logic [3:0] push, ser_route_in, ovf_set;
  logic [7:0] push_data [NUM_CH];
  logic [1:0] cur;
  logic pop, boundary, rx_valid, tx_busy, tx_start;
  logic [7:0] rx_data, tx_data;
  logic [5:0] ser_level;

  assign boundary = progressive ? frame_tick : field_tick; // [R05]
  assign ser_level = cnt[ser_ch];

  // The serial port feeds at most one stream [R02]
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ser_route_in[i] = ser_en && !ser_dir && ser_ch == 2'(i);
      net_in_ready[i] = !ser_route_in[i] && cnt[i] != FIFO_FULL; // [R10]
      push[i] = ser_route_in[i] ? (rx_valid && cnt[i] != FIFO_FULL)
                                : (net_in_valid[i] && net_in_ready[i]);
      push_data[i] = ser_route_in[i] ? rx_data : net_in_data[8*i +: 8];
      // An ignored pause loses the excess here [R07]
      ovf_set[i] = ser_route_in[i] && rx_valid && cnt[i] == FIFO_FULL;
    end
  end

  // Pop while the current stream has credit and data
  assign pop = (!ins_valid || ins_ready) && credit[cur] != 8'h00 && cnt[cur] != 6'h00;

  // Buffer pointers and storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        wp[i] <= '0;
        rp[i] <= '0;
        cnt[i] <= 6'h00;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (push[i]) begin
          mem[i][wp[i]] <= push_data[i];
          wp[i] <= wp[i] + 1'b1;
        end
        if (pop && cur == 2'(i)) begin
          rp[i] <= rp[i] + 1'b1;
        end
        cnt[i] <= cnt[i] + 6'(push[i]) - 6'(pop && cur == 2'(i));
      end
    end
  end

  // Credit is reloaded, not accumulated, so unused quota never carries over
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        credit[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (boundary) begin
          credit[i] <= quota[i]; // [R21] [R10] [R03]
        end else if (pop && cur == 2'(i)) begin
          credit[i] <= credit[i] - 8'h01; // [R21]
        end
      end
    end
  end

  // Drain to the inserter, streams visited round robin
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ins_valid <= 1'b0;
      ins_chan <= 2'h0;
      ins_data <= 8'h00;
      cur <= 2'h0;
    end else begin
      if (pop) begin
        ins_valid <= 1'b1;
        ins_chan <= cur;
        ins_data <= mem[cur][rp[cur]]; // [R21]
      end else begin
        if (ins_ready) begin
          ins_valid <= 1'b0;
        end
        if (!ins_valid || ins_ready) begin
          cur <= cur + 2'h1;
        end
      end
    end
  end

  // Sticky overflow; a new overflow beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ovf <= 4'h0;
    end else begin
      ovf <= (ovf & ~((wr_fire && aw_addr == ADDR_STATUS && w_strb[0])
             ? w_data[ST_OVF +: 4] : 4'h0)) | ovf_set; // [R07]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial flow control and transmit arbitration
  flow_state_type flow_state;
  logic flow_send, ser_route_out, net_take;
  logic [7:0] flow_char;

  // Pause near full, resume when drained or flow is off
  always_comb begin
    flow_send = 1'b0;
    flow_char = PAUSE_CHAR;
    case (flow_state)
      FLOW_RUN: begin
        flow_send = flow_on && ser_en && !ser_dir && ser_level >= XOFF_LEVEL; // [R06] [R20]
      end
      FLOW_PAUSED: begin
        flow_send = !flow_on || !ser_en || ser_dir || ser_level <= XON_LEVEL; // [R06]
        flow_char = RESUME_CHAR; // [R20]
      end
      default: flow_send = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flow_state <= FLOW_RUN;
    end else if (flow_send && !tx_busy) begin
      case (flow_state)
        FLOW_RUN: flow_state <= FLOW_PAUSED; // [R06]
        FLOW_PAUSED: flow_state <= FLOW_RUN;
        default: flow_state <= FLOW_RUN;
      endcase
    end
  end

  // Serial extract bytes wait behind flow characters.
  // A decode baud below the stream rate simply back-pressures here.
  assign ser_route_out = ser_en && ser_dir && ext_chan == ser_ch; // [R02] [R09]
  assign ext_ready = ser_route_out ? (!tx_busy && !flow_send)
                                   : (!net_out_valid || net_out_ready);
  assign net_take = ext_valid && ext_ready && !ser_route_out;
  assign tx_start = !tx_busy && (flow_send || (ext_valid && ser_route_out));
  assign tx_data = flow_send ? flow_char : ext_data;

  // Network extract output register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      net_out_valid <= 1'b0;
      net_out_chan <= 2'h0;
      net_out_data <= 8'h00;
    end else if (net_take) begin
      net_out_valid <= 1'b1;
      net_out_chan <= ext_chan;
      net_out_data <= ext_data;
    end else if (net_out_ready) begin
      net_out_valid <= 1'b0;
    end
  end

  serial_uart u_uart (
    .clk(clk),
    .reset_n(reset_n),
    .divisor(baud_div(baud_sel)), // [R15] [R03]
    .bits8(bits8),
    .parity(parity),
    .stop2(stop2),
    .rx_pin(ser_rx),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_start(tx_start),
    .tx_data(tx_data),
    .tx_busy(tx_busy),
    .tx_pin(ser_tx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_CTRL: begin
        rd_word[CTRL_SER_EN] = ser_en;
        rd_word[CTRL_SER_CH +: 2] = ser_ch;
        rd_word[CTRL_SER_DIR] = ser_dir;
      end
      ADDR_SERIAL: begin
        rd_word[SER_DIFF] = ser_diff_mode;
        rd_word[SER_BAUD +: 3] = baud_sel;
        rd_word[SER_BITS8] = bits8;
        rd_word[SER_PAR +: 2] = parity;
        rd_word[SER_STOP2] = stop2;
        rd_word[SER_FLOW] = flow_on;
      end
      ADDR_NET: begin
        rd_word[NET_CLIENT +: 4] = net_role_client;
        rd_word[NET_REAR +: 4] = net_use_rear_jack;
        rd_word[NET_PORT +: 16] = RAW_STREAM_PORT; // [R12]
      end
      ADDR_STATUS: begin
        rd_word[ST_PAUSED] = flow_state == FLOW_PAUSED;
        rd_word[ST_OVF +: 4] = ovf;
        rd_word[ST_LEVEL +: 6] = ser_level;
      end
      default: begin
        if (s_axi_araddr >= ADDR_QUOTA0 && addr_ok(s_axi_araddr)) begin
          rd_word[7:0] = quota[s_axi_araddr[3:2]];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* File: testbench/pacer_chk.sv */
// Port-level assertions for the serial stream pacer
`timescale 1ns/100ps
module pacer_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ins_valid,
  input wire logic ins_ready,
  input wire logic [1:0] ins_chan,
  input wire logic [7:0] ins_data,
  input wire logic ext_valid,
  input wire logic ext_ready,
  input wire logic net_out_valid,
  input wire logic net_out_ready,
  input wire logic [1:0] net_out_chan,
  input wire logic [7:0] net_out_data,
  input wire logic [15:0] raw_stream_port
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // No new request while an answer waits; write answer two cycles after both handshakes, read data the next cycle
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write open in response");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read open in response");
  wr_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  rd_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  ////////////////////////////////////////////////////////////////////////////
  // Socket port is fixed; a network byte needs a taken extract byte; a byte holds until it is taken
  port_fixed_a: assert property (raw_stream_port == 16'h1E6C)
    else $error("socket port wrong");
  out_cause_a: assert property ($rose(net_out_valid) |-> $past(ext_valid && ext_ready))
    else $error("byte from nowhere");
  out_hold_a: assert property (net_out_valid && !net_out_ready |=> net_out_valid
    && $stable(net_out_data) && $stable(net_out_chan)) else $error("network byte dropped");
  ins_hold_a: assert property (ins_valid && !ins_ready |=> ins_valid
    && $stable(ins_data) && $stable(ins_chan)) else $error("insert byte dropped");
  cover property (s_axi_bvalid);
  cover property (s_axi_rvalid);
  cover property (ins_valid && ins_ready);
  cover property (ext_valid && ext_ready);
endmodule

/* File: testbench/serial_peer.sv */
// Serial link partner: sends bytes, decodes what it receives
`timescale 1ns/100ps
module serial_peer
  import vanc_pacer_pkg::*;
#(
  parameter int DIV = 1736
) (
  input wire logic clk,
  input wire logic ser_tx,
  output logic ser_rx
);
  logic [7:0] got = '0;
  logic [7:0] sh;
  logic stop_ok = '0;
  logic paused = '0;
  int n_got = 0;
  initial ser_rx = 1'h1;
  // Start, eight data bits LSB first, stop; waits while paused
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    while (paused) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      ser_rx <= f[i];
      repeat (DIV) @(posedge clk);
    end
  endtask
  // Mid-bit receiver; flow characters steer the sender
  always begin
    @(negedge ser_tx);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk);
      sh[i] = ser_tx;
    end
    repeat (DIV) @(posedge clk);
    stop_ok = ser_tx;
    got = sh;
    n_got++;
    if (sh == PAUSE_CHAR) paused = 1'h1;
    else if (sh == RESUME_CHAR) paused = 1'h0;
  end
endmodule

/* File: testbench/vanc_serial_stream_pacer_test.sv */
// Self-checking bench for the serial stream pacer
`timescale 1ns/100ps
module vanc_serial_stream_pacer_test;
  import vanc_pacer_pkg::*;
  logic clk = '0, reset_n = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, ins_data, ext_data = '0, net_out_data;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, net_in_data = '0;
  logic [3:0] s_axi_wstrb = 4'hF, net_in_valid = '0, net_in_ready;
  logic [3:0] net_role_client, net_use_rear_jack;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_rvalid, s_axi_bvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready, ins_valid, ext_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp, ins_chan, ext_chan = '0, net_out_chan;
  logic field_tick = '0, frame_tick = '0, progressive = '0, ins_ready = '1;
  logic ext_valid = '0, net_out_valid, net_out_ready = '0, ser_diff_mode, ser_rx, ser_tx;
  logic [15:0] raw_stream_port;
  int n_fail = 0, total_checks = 0;
  vanc_serial_stream_pacer i_dut (.*);
  serial_peer i_peer (.clk, .ser_tx, .ser_rx);
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Address and data together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask
  task automatic tick(input logic f);
    if (f) frame_tick <= 1'h1;
    else field_tick <= 1'h1;
    @(posedge clk);
    frame_tick <= 1'h0;
    field_tick <= 1'h0;
  endtask
  // Valid held across bytes
  task automatic push(input int ch, input int n, input logic [7:0] b0);
    for (int k = 0; k < n; k++) begin
      net_in_valid[ch] <= 1'h1;
      net_in_data[8*ch+:8] <= b0 + 8'(k);
      do @(posedge clk); while (!net_in_ready[ch]);
    end
    net_in_valid <= 4'h0;
  endtask
  // Stall first: bytes must wait, not vanish
  task automatic drain(input int n, input logic [1:0] ch, input logic [7:0] b0);
    int k;
    k = 0;
    ins_ready <= 1'h0;
    repeat (4) @(posedge clk);
    ins_ready <= 1'h1;
    repeat (60) begin
      @(posedge clk);
      if (ins_valid && ins_ready) begin
        chk(ins_chan, ch);
        chk(ins_data, b0 + 8'(k));
        k++;
      end
    end
    chk(k, n);
  endtask
  task automatic ext_send(input logic [1:0] ch, input logic [7:0] d);
    ext_valid <= 1'h1;
    ext_chan <= ch;
    ext_data <= d;
    do @(posedge clk); while (!ext_ready);
    ext_valid <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADDR_SERIAL, 32'h19, RESP_OKAY);
    rd(ADDR_NET, 32'h1E6C0000, RESP_OKAY);
    rd(ADDR_QUOTA0, 32'h64, RESP_OKAY);
    chk(ser_diff_mode, 1'h1);
    chk(raw_stream_port, 16'h1E6C);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'hFFFFFFFF, RESP_SLVERR);
    wr(ADDR_SERIAL, 32'h18, RESP_OKAY);
    chk(ser_diff_mode, 1'h0);
    wr(ADDR_SERIAL, 32'h19, RESP_OKAY);
    wr(ADDR_NET, 32'hFFFF00A5, RESP_OKAY);
    chk(net_role_client, 4'h5);
    chk(net_use_rear_jack, 4'hA);
    rd(ADDR_NET, 32'h1E6C00A5, RESP_OKAY);
    $display("registers done");
  endtask
  // Quota 3, 5 queued: wrong tick drains none, rest waits
  task automatic t_quota();
    wr(ADDR_QUOTA0 + 8'h04, 32'h3, RESP_OKAY);
    push(1, 5, 8'hA0);
    tick(1'h1);
    drain(0, 2'h1, 8'hA0);
    tick(1'h0);
    drain(3, 2'h1, 8'hA0);
    progressive <= 1'h1;
    tick(1'h1);
    drain(2, 2'h1, 8'hA3);
    $display("quota done");
  endtask
  task automatic t_ext();
    ext_send(2'h2, 8'h5A);
    repeat (3) @(posedge clk);
    chk(net_out_valid, 1'h1);
    chk(net_out_chan, 2'h2);
    chk(net_out_data, 8'h5A);
    net_out_ready <= 1'h1;
    $display("extract done");
  endtask
  task automatic t_serial();
    int n0;
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    chk(net_in_ready[0], 1'h0);
    ins_ready <= 1'h0;
    i_peer.send(8'h3C);
    repeat (4) @(posedge clk);
    tick(1'h1);
    drain(1, 2'h0, 8'h3C);
    wr(ADDR_CTRL, 32'h0B, RESP_OKAY);
    n0 = i_peer.n_got;
    ext_send(2'h1, 8'hC5);
    while (i_peer.n_got == n0) @(posedge clk);
    chk(i_peer.got, 8'hC5);
    chk(i_peer.stop_ok, 1'h1);
    $display("serial done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_quota();
    t_ext();
    t_serial();
    finish_test();
  end
  // Two serial bytes take about 35000 cycles
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule
bind vanc_serial_stream_pacer pacer_chk i_chk (.*);
